/* logic/cpsf_alu_flags.v */
// combinational result and flag computation for one instruction
`timescale 1ns/10ps
`default_nettype none
`include "cpsf_defs.vh"

module cpsf_alu_flags
(
   input  wire [3:0] op,          // instruction code
   input  wire [7:0] opnd_a,      // first operand
   input  wire [7:0] opnd_b,      // second operand
   input  wire       carry_in,    // current carry flag
   output reg  [7:0] result,      // operation result
   output reg  [3:0] flags,       // new c, ac, z, ov
   output reg  [3:0] upd          // which flags the op touches
);

   reg [8:0] sum;
   reg [4:0] lo_sum;
   reg [7:0] b_eff;
   reg       cin;
   reg [7:0] low7;

   always @*
   begin
      result = 8'h00;
      flags  = 4'h0;
      upd    = 4'h0;
      b_eff  = opnd_b;
      cin    = 1'b0;
      case (op)
         `CPSF_OP_ADC : cin = carry_in;
         `CPSF_OP_SUB :
         begin
            b_eff = ~opnd_b;
            cin   = 1'b1;
         end
         `CPSF_OP_SBC :
         begin
            b_eff = ~opnd_b;
            cin   = carry_in;
         end
         default : cin = 1'b0;
      endcase
      // subtraction as a plus not b, so carry out means no borrow
      sum    = {1'b0, opnd_a} + {1'b0, b_eff} + {8'h00, cin};
      lo_sum = {1'b0, opnd_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
      low7   = {1'b0, opnd_a[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, cin};
      case (op)
         `CPSF_OP_ADD, `CPSF_OP_ADC, `CPSF_OP_SUB, `CPSF_OP_SBC :
         begin
            result = sum[7:0];
            flags[`CPSF_BIT_CARRY_LO] = sum[8];
            flags[`CPSF_BIT_HALF] = lo_sum[4];
            // carry in xor out of msb
            flags[`CPSF_BIT_WRAP] = low7[7] ^ sum[8];
            upd = 4'hf;
         end
         `CPSF_OP_AND : result = opnd_a & opnd_b;
         `CPSF_OP_OR  : result = opnd_a | opnd_b;
         `CPSF_OP_XOR : result = opnd_a ^ opnd_b;
         `CPSF_OP_INC : result = opnd_a + 8'h01;
         `CPSF_OP_DEC : result = opnd_a - 8'h01;
         `CPSF_OP_RLC :
         begin
            result = {opnd_a[6:0], carry_in};
            flags[`CPSF_BIT_CARRY_LO] = opnd_a[7];
            upd[`CPSF_BIT_CARRY_LO] = 1'b1;
         end
         `CPSF_OP_RRC :
         begin
            result = {carry_in, opnd_a[7:1]};
            flags[`CPSF_BIT_CARRY_LO] = opnd_a[0];
            upd[`CPSF_BIT_CARRY_LO] = 1'b1;
         end
         `CPSF_OP_MOV : result = opnd_a;
         default      : result = 8'h00;
      endcase
      flags[`CPSF_BIT_ZERO] = (result == 8'h00);
      case (op)
         `CPSF_OP_AND, `CPSF_OP_OR, `CPSF_OP_XOR, `CPSF_OP_INC, `CPSF_OP_DEC :
            upd[`CPSF_BIT_ZERO] = 1'b1;
         default : upd[`CPSF_BIT_ZERO] = upd[`CPSF_BIT_ZERO];
      endcase
   end

endmodule // cpsf_alu_flags
`default_nettype wire

/* logic/cpsf_defs.vh */
// constants for the processor flag register block
`ifndef CPSF_DEFS_VH
`define CPSF_DEFS_VH

// flag bit positions
`define CPSF_BIT_CARRY      0
`define CPSF_BIT_CARRY_LO   0
`define CPSF_BIT_HALF       1
`define CPSF_BIT_ZERO       2
`define CPSF_BIT_WRAP       3
`define CPSF_BIT_PDOWN      4
`define CPSF_BIT_WDEXP      5
`define CPSF_ARITH_MASK     8'h0f
`define CPSF_FLAGS_RESET    8'h00
`define CPSF_ARITH_RESET    4'h0

// register byte offsets
`define CPSF_OFS_FLAGS      4'h0
`define CPSF_OFS_EVT_STAT   4'h4
`define CPSF_OFS_EVT_MASK   4'h8
`define CPSF_OFS_SW_CMD     4'hc
`define CPSF_ADDR_BITS      5
`define CPSF_OFS_RESULT     5'h10

// event status bit positions
`define CPSF_EVT_WDEXP      0
`define CPSF_EVT_HALT       1
`define CPSF_EVT_KICK       2
`define CPSF_EVT_WRAP       3
`define CPSF_EVT_BITS       4
`define CPSF_EVT_RESET      4'h0

// software command fields
`define CPSF_CMD_OP_LSB     0
`define CPSF_CMD_A_LSB      8
`define CPSF_CMD_B_LSB      16
`define CPSF_CMD_PEND_BIT   31
`define CPSF_CMD_RESET      32'h0000_0000

// instruction codes
`define CPSF_OP_ADD         4'h0
`define CPSF_OP_ADC         4'h1
`define CPSF_OP_SUB         4'h2
`define CPSF_OP_SBC         4'h3
`define CPSF_OP_AND         4'h4
`define CPSF_OP_OR          4'h5
`define CPSF_OP_XOR         4'h6
`define CPSF_OP_RLC         4'h7
`define CPSF_OP_RRC         4'h8
`define CPSF_OP_INC         4'h9
`define CPSF_OP_DEC         4'ha
`define CPSF_OP_MOV         4'hb
`define CPSF_OP_HALT        4'hc
`define CPSF_OP_KICK        4'hd

// bus responses
`define CPSF_RESP_OKAY      2'h0
`define CPSF_RESP_SLVERR    2'h2

`endif

/* logic/cpsf_sys_flags.v */
// power-down and watchdog-expired system flags
`timescale 1ns/10ps
`default_nettype none
`include "cpsf_defs.vh"

module cpsf_sys_flags
(
   input  wire aclk,              // core clock
   input  wire aresetn,           // power-up reset, active low
   input  wire halt_exec,         // halt instruction executes
   input  wire kick_exec,         // watchdog_kick_instr executes
   input  wire wd_timeout,        // watchdog_timer_unit time-out pulse
   output reg  powerdown_flag,    // power-down flag
   output reg  watchdog_expired_flag // watchdog-expired flag
);

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         powerdown_flag        <= 1'b0;
         watchdog_expired_flag <= 1'b0;
      end
      else
      begin
         if (halt_exec)
            powerdown_flag <= 1'b1;
         else if (kick_exec)
            powerdown_flag <= 1'b0;
         if (wd_timeout)
            watchdog_expired_flag <= 1'b1;
         else if (kick_exec || halt_exec)
            watchdog_expired_flag <= 1'b0;
      end
   end

endmodule // cpsf_sys_flags
`default_nettype wire

/* logic/cpsf_top.v */
// processor flag register with core port and axi4-lite slave
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "cpsf_defs.vh"

module cpsf_top
(
   input  wire        aclk,          // core clock, 125 mhz
   input  wire        aresetn,       // synchronous reset, active low
   input  wire [4:0]  s_axi_awaddr,  // write address
   input  wire        s_axi_awvalid, // write address valid
   output reg         s_axi_awready, // write address ready
   input  wire [31:0] s_axi_wdata,   // write data
   input  wire [3:0]  s_axi_wstrb,   // write byte enables
   input  wire        s_axi_wvalid,  // write data valid
   output reg         s_axi_wready,  // write data ready
   output reg  [1:0]  s_axi_bresp,   // write response
   output reg         s_axi_bvalid,  // write response valid
   input  wire        s_axi_bready,  // write response ready
   input  wire [4:0]  s_axi_araddr,  // read address
   input  wire        s_axi_arvalid, // read address valid
   output reg         s_axi_arready, // read address ready
   output reg  [31:0] s_axi_rdata,   // read data
   output reg  [1:0]  s_axi_rresp,   // read response
   output reg         s_axi_rvalid,  // read data valid
   input  wire        s_axi_rready,  // read data ready
   input  wire        instr_valid,   // core issues an instruction
   input  wire [3:0]  instr_op,      // instruction code
   input  wire [7:0]  instr_opnd_a,  // first operand
   input  wire [7:0]  instr_opnd_b,  // second operand
   input  wire        wd_timeout,    // watchdog_timer_unit time-out
   output reg  [7:0]  result_data,   // instruction result
   output reg         result_valid,  // result completes, one cycle
   output reg  [7:0]  flags_out,     // processor_flags image
   output reg         irq            // interrupt, active high level
);

   // register select codes from the address decode
   localparam [2:0] SEL_NONE   = 3'h0;
   localparam [2:0] SEL_FLAGS  = 3'h1;
   localparam [2:0] SEL_STAT   = 3'h2;
   localparam [2:0] SEL_MASK   = 3'h3;
   localparam [2:0] SEL_CMD    = 3'h4;
   localparam [2:0] SEL_RESULT = 3'h5;

   // register index decode shared by read and write paths
   function [2:0] reg_sel;
      input [4:0] addr;
      begin
         case (addr)
            {1'b0, `CPSF_OFS_FLAGS}    : reg_sel = SEL_FLAGS;
            {1'b0, `CPSF_OFS_EVT_STAT} : reg_sel = SEL_STAT;
            {1'b0, `CPSF_OFS_EVT_MASK} : reg_sel = SEL_MASK;
            {1'b0, `CPSF_OFS_SW_CMD}   : reg_sel = SEL_CMD;
            `CPSF_OFS_RESULT           : reg_sel = SEL_RESULT;
            default                    : reg_sel = SEL_NONE;
         endcase
      end
   endfunction

   reg  [3:0]  arith_reg;
   reg  [3:0]  arith_next;
   reg  [3:0]  evt_reg;
   reg  [3:0]  evt_next;
   reg  [3:0]  mask_reg;
   reg  [31:0] cmd_reg;
   reg         cmd_pend_reg;
   reg         aw_have_reg;
   reg  [4:0]  aw_addr_reg;
   reg         w_have_reg;
   reg  [31:0] w_data_reg;
   reg  [3:0]  w_strb_reg;
   reg  [31:0] rd_word;
   reg  [3:0]  op_sel;
   reg  [7:0]  a_sel;
   reg  [7:0]  b_sel;
   reg         exec_go;
   reg         pd_next;
   reg         wx_next;
   reg  [3:0]  mask_next;

   wire        aw_take;
   wire        w_take;
   wire        do_write;
   wire        aw_have_next;
   wire        w_have_next;
   wire        bvalid_next;
   wire        ar_take;
   wire        rvalid_next;
   wire [2:0]  wr_sel;
   wire [2:0]  rd_sel;
   wire        wr_low;
   wire [7:0]  alu_result;
   wire [3:0]  alu_flags;
   wire [3:0]  alu_upd;
   wire        halt_exec;
   wire        kick_exec;
   wire        pd_flag;
   wire        wx_flag;
   wire [7:0]  flags_now;
   wire [3:0]  evt_set;
   wire        sw_issue;
   wire        wr_flags;
   wire        wr_stat;
   wire        wr_mask;
   wire        wr_cmd;
   wire        wr_err;
   wire        rd_err;
   wire [7:0]  flags_next;
   wire        irq_next;

   // write channel: address and data taken in either order
   assign aw_take      = s_axi_awvalid & s_axi_awready;
   assign w_take       = s_axi_wvalid & s_axi_wready;
   assign do_write     = aw_have_reg & w_have_reg & ~s_axi_bvalid;
   assign aw_have_next = (aw_have_reg | aw_take) & ~do_write;
   assign w_have_next  = (w_have_reg | w_take) & ~do_write;
   assign bvalid_next  = do_write | (s_axi_bvalid & ~s_axi_bready);
   assign wr_sel       = reg_sel(aw_addr_reg);
   assign wr_low       = do_write & w_strb_reg[0];

   // per-register write strobes; 8-bit registers need byte lane 0
   assign wr_flags     = wr_low & (wr_sel == SEL_FLAGS);
   assign wr_stat      = wr_low & (wr_sel == SEL_STAT);
   assign wr_mask      = wr_low & (wr_sel == SEL_MASK);
   assign wr_cmd       = do_write & (wr_sel == SEL_CMD) & (&w_strb_reg[2:0]);
   // unmapped or read-only targets answer with an error
   assign wr_err       = (wr_sel == SEL_NONE) | (wr_sel == SEL_RESULT);

   // read channel: one read in flight
   assign ar_take      = s_axi_arvalid & s_axi_arready;
   assign rvalid_next  = ar_take | (s_axi_rvalid & ~s_axi_rready);
   assign rd_sel       = reg_sel(s_axi_araddr);
   assign rd_err       = (rd_sel == SEL_NONE);

   // core instruction has priority over a queued software command
   assign sw_issue  = cmd_pend_reg & ~instr_valid;

   always @*
   begin
      op_sel  = instr_op;
      a_sel   = instr_opnd_a;
      b_sel   = instr_opnd_b;
      exec_go = instr_valid;
      if (sw_issue)
      begin
         op_sel  = cmd_reg[`CPSF_CMD_OP_LSB +: 4];
         a_sel   = cmd_reg[`CPSF_CMD_A_LSB +: 8];
         b_sel   = cmd_reg[`CPSF_CMD_B_LSB +: 8];
         exec_go = 1'b1;
      end
   end

   assign halt_exec = exec_go & (op_sel == `CPSF_OP_HALT);
   assign kick_exec = exec_go & (op_sel == `CPSF_OP_KICK);

   cpsf_alu_flags u_alu
   (
      .op       (op_sel),
      .opnd_a   (a_sel),
      .opnd_b   (b_sel),
      .carry_in (arith_reg[`CPSF_BIT_CARRY_LO]),
      .result   (alu_result),
      .flags    (alu_flags),
      .upd      (alu_upd)
   );

   cpsf_sys_flags u_sys
   (
      .aclk                  (aclk),
      .aresetn               (aresetn),
      .halt_exec             (halt_exec),
      .kick_exec             (kick_exec),
      .wd_timeout            (wd_timeout),
      .powerdown_flag        (pd_flag),
      .watchdog_expired_flag (wx_flag)
   );

   // fixed bit layout, bits 7:6 zero
   assign flags_now = {2'b00, wx_flag, pd_flag, arith_reg};

   // system flag values after this edge, same priorities as the flag module
   always @*
   begin
      pd_next = pd_flag;
      if (halt_exec)
         pd_next = 1'b1;
      else if (kick_exec)
         pd_next = 1'b0;
      wx_next = wx_flag;
      if (wd_timeout)
         wx_next = 1'b1;
      else if (kick_exec || halt_exec)
         wx_next = 1'b0;
   end

   always @*
   begin
      arith_next = arith_reg;
      // software reaches only the arithmetic bits
      if (wr_flags)
         arith_next = w_data_reg[3:0];
      // only flags the op touches change
      if (exec_go)
         arith_next = (arith_next & ~alu_upd) | (alu_flags & alu_upd);
   end

   // image after this edge, so flags_out agrees with the flag register
   assign flags_next = {2'b00, wx_next, pd_next, arith_next};

   assign evt_set[`CPSF_EVT_WDEXP] = wd_timeout;
   assign evt_set[`CPSF_EVT_HALT]  = halt_exec;
   assign evt_set[`CPSF_EVT_KICK]  = kick_exec;
   assign evt_set[`CPSF_EVT_WRAP]  = exec_go & alu_upd[`CPSF_BIT_WRAP]
                                     & alu_flags[`CPSF_BIT_WRAP];

   // write-one-to-clear, a new event wins over the clear
   always @*
   begin
      evt_next = evt_reg;
      if (wr_stat)
         evt_next = evt_reg & ~w_data_reg[3:0];
      evt_next = evt_next | evt_set;
   end

   // mask takes a byte-lane-0 write
   always @*
   begin
      mask_next = mask_reg;
      if (wr_mask)
         mask_next = w_data_reg[3:0];
   end

   // level interrupt from unmasked sticky events
   assign irq_next = |(evt_next & mask_next);

   always @*
   begin
      case (rd_sel)
         SEL_FLAGS  : rd_word = {24'h000000, flags_now};
         SEL_STAT   : rd_word = {28'h0000000, evt_reg};
         SEL_MASK   : rd_word = {28'h0000000, mask_reg};
         SEL_CMD    : rd_word = {cmd_pend_reg, cmd_reg[30:0]};
         SEL_RESULT : rd_word = {16'h0000, flags_now, result_data};
         default : rd_word = 32'h00000000;
      endcase
   end

   // bus slave handshake state
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_reg   <= 1'b0;
         aw_addr_reg   <= 5'h00;
         w_have_reg    <= 1'b0;
         w_data_reg    <= 32'h00000000;
         w_strb_reg    <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `CPSF_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= `CPSF_RESP_OKAY;
         s_axi_rdata   <= 32'h00000000;
      end
      else
      begin
         aw_have_reg   <= aw_have_next;
         w_have_reg    <= w_have_next;
         if (aw_take)
            aw_addr_reg <= s_axi_awaddr;
         if (w_take)
         begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         s_axi_awready <= ~aw_have_next & ~bvalid_next;
         s_axi_wready  <= ~w_have_next & ~bvalid_next;
         s_axi_bvalid  <= bvalid_next;
         if (do_write)
            s_axi_bresp <= wr_err ? `CPSF_RESP_SLVERR : `CPSF_RESP_OKAY;
         s_axi_arready <= ~rvalid_next;
         s_axi_rvalid  <= rvalid_next;
         if (ar_take)
         begin
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_err ? `CPSF_RESP_SLVERR : `CPSF_RESP_OKAY;
         end
      end
   end

   // flag, event and command state
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arith_reg    <= `CPSF_ARITH_RESET;
         evt_reg      <= `CPSF_EVT_RESET;
         mask_reg     <= `CPSF_EVT_RESET;
         cmd_reg      <= `CPSF_CMD_RESET;
         cmd_pend_reg <= 1'b0;
         result_data  <= 8'h00;
         result_valid <= 1'b0;
         flags_out    <= `CPSF_FLAGS_RESET;
         irq          <= 1'b0;
      end
      else
      begin
         arith_reg <= arith_next;
         evt_reg   <= evt_next;
         mask_reg  <= mask_next;
         // a command write queues one operation; a rewrite replaces it
         if (wr_cmd)
         begin
            cmd_reg      <= w_data_reg;
            cmd_pend_reg <= 1'b1;
         end
         else if (sw_issue)
            cmd_pend_reg <= 1'b0;
         result_valid <= exec_go;
         if (exec_go)
            result_data <= alu_result;
         flags_out <= flags_next;
         irq       <= irq_next;
      end
   end

   // no stack path exists; flags are never pushed on call or interrupt

endmodule // cpsf_top
`default_nettype wire

/* testbench/cpsf_top_props.sv */
// concurrent checks on the processor flag register ports
`timescale 1ns/10ps
`default_nettype none
module cpsf_props
(
   input wire logic       aclk,         // core clock
   input wire logic       aresetn,      // reset, active low
   input wire logic       instr_valid,  // instruction issued
   input wire logic [3:0] instr_op,     // instruction code
   input wire logic [7:0] instr_opnd_a, // first operand
   input wire logic [7:0] instr_opnd_b, // second operand
   input wire logic       wd_timeout,   // watchdog time-out
   input wire logic [7:0] result_data,  // result
   input wire logic       result_valid, // result strobe
   input wire logic [7:0] flags_out     // flag image
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire [8:0] add_sum  = {1'b0, instr_opnd_a} + {1'b0, instr_opnd_b};
   wire [4:0] half_sum = {1'b0, instr_opnd_a[3:0]} + {1'b0, instr_opnd_b[3:0]};
   wire       add_wrap = (instr_opnd_a[7] == instr_opnd_b[7]) && (add_sum[7] != instr_opnd_a[7]);
   wire       is_add   = instr_valid && (instr_op == 4'h0);

   chk_top_bits: assert property (flags_out[7:6] == 2'b00)
      else $error("flag bits 7:6 not zero");
   chk_result_strobe: assert property (instr_valid |=> result_valid)
      else $error("no result strobe");
   chk_no_spurious: assert property (!instr_valid |=> !result_valid)
      else $error("result strobe without instruction");
   chk_add_carry: assert property (is_add |=> flags_out[0] == $past(add_sum[8]))
      else $error("add carry wrong");
   chk_add_half: assert property (is_add |=> flags_out[1] == $past(half_sum[4]))
      else $error("add half carry wrong");
   chk_add_wrap: assert property (is_add |=> flags_out[3] == $past(add_wrap))
      else $error("add wrap flag wrong");
   chk_logic_zero: assert property (instr_valid && instr_op inside {4'h4, 4'h5, 4'h6}
      |=> flags_out[2] == (result_data == 8'h00)) else $error("zero flag wrong");
   chk_rot_carry: assert property (instr_valid && instr_op == 4'h7
      |=> flags_out[0] == $past(instr_opnd_a[7])) else $error("rotate carry wrong");
   chk_halt_sets: assert property (instr_valid && instr_op == 4'hc && !wd_timeout
      |=> flags_out[5:4] == 2'b01) else $error("halt flags wrong");
   chk_kick_clears: assert property (instr_valid && instr_op == 4'hd && !wd_timeout
      |=> flags_out[5:4] == 2'b00) else $error("kick flags wrong");
   chk_timeout_sets: assert property (wd_timeout |=> flags_out[5])
      else $error("time-out did not set flag");
   chk_pd_cause: assert property (!$stable(flags_out[4]) |-> $past(instr_valid)
      && $past(instr_op) inside {4'hc, 4'hd}) else $error("power-down flag changed");
   chk_wd_cause: assert property ($rose(flags_out[5]) |-> $past(wd_timeout))
      else $error("watchdog flag rose without time-out");

   cov_halt: cover property (instr_valid && instr_op == 4'hc);
   cov_timeout: cover property (wd_timeout);
   cov_wrap: cover property (is_add ##1 flags_out[3]);
endmodule // cpsf_props

bind cpsf_top cpsf_props u_props (.aclk, .aresetn, .instr_valid, .instr_op, .instr_opnd_a,
   .instr_opnd_b, .wd_timeout, .result_data, .result_valid, .flags_out);
`default_nettype wire

/* testbench/tb_cpu_status_flag_register.sv */
// self-checking bench for the processor flag register
`timescale 1ns/10ps
`default_nettype none
`include "cpsf_defs.vh"
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin n_mismatch++; \
   $display("BAD %s exp %h got %h", nm, e, s); end end
module tb_cpu_status_flag_register;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rd;
   logic [3:0]  wstrb = 4'hf, instr_op = 4'h0;
   logic        instr_valid = 1'b0, wd_timeout = 1'b0;
   logic [7:0]  opnd_a = 8'h00, opnd_b = 8'h00;
   logic [1:0]  rsp;
   logic [15:0] rnd = 16'hd362;
   wire         awready, wready, bvalid, arready, rvalid, result_valid, irq;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [7:0]  result_data, flags_out;
   integer      n_mismatch = 0, total_checks = 0, cyc = 0, i;
   integer      m_flg = 0, m_st = 0, m_msk = 0, m_res = 0;
   logic [19:0] dir [0:7] = '{20'h07f01, 20'h0ff01, 20'h10f00, 20'h20505,
                              20'h20001, 20'h38001, 20'h78100, 20'h80100};

   cpsf_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .instr_valid(instr_valid), .instr_op(instr_op),
      .instr_opnd_a(opnd_a), .instr_opnd_b(opnd_b), .wd_timeout(wd_timeout),
      .result_data(result_data), .result_valid(result_valid), .flags_out(flags_out),
      .irq(irq));

   always #4 aclk = ~aclk;

   function automatic [15:0] lfsr(input [15:0] s);
      lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task finish_test;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic axw(input [4:0] ad, input [31:0] d);
      @(posedge aclk);
      awaddr <= ad; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      bready <= 1'b1;
      do @(posedge aclk); while (!bvalid);
      rsp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rdchk(input [4:0] ad, input integer ev, input [1:0] er);
      @(posedge aclk);
      araddr <= ad; arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0; rready <= 1'b1;
      do @(posedge aclk); while (!rvalid);
      rd = rdata; rsp = rresp; rready <= 1'b0;
      `CHK("rdata", ev, rd)
      `CHK("rresp", er, rsp)
   endtask

   task automatic wr(input [4:0] ad, input [31:0] d, input [1:0] er);
      axw(ad, d);
      `CHK("bresp", er, rsp)
      if (ad == `CPSF_OFS_FLAGS) m_flg = (m_flg & 8'h30) | (d & 8'h0f);
      if (ad == `CPSF_OFS_EVT_STAT) m_st = m_st & ~d & 4'hf;
      if (ad == `CPSF_OFS_EVT_MASK) m_msk = d & 4'hf;
   endtask

   task automatic mop(input [3:0] op, input integer a, input integer b);
      integer bb, ci, s, c, h, v;
      c = m_flg & 1;
      bb = (op == `CPSF_OP_SUB || op == `CPSF_OP_SBC) ? b ^ 255 : b;
      ci = (op == `CPSF_OP_ADD) ? 0 : (op == `CPSF_OP_SUB) ? 1 : c;
      s = a + bb + ci;
      h = ((a & 15) + (bb & 15) + ci) >> 4;
      v = (((a & 127) + (bb & 127) + ci) >> 7) ^ (s >> 8);
      case (op)
         4'h0, 4'h1, 4'h2, 4'h3:
         begin
            m_res = s & 255;
            m_flg = (m_flg & 8'h30) | (v << 3) | ((m_res == 0) << 2) | (h << 1) | (s >> 8);
            if (v) m_st = m_st | 8;
         end
         4'h4: m_res = a & b;
         4'h5: m_res = a | b;
         4'h6: m_res = a ^ b;
         4'h7: m_res = ((a << 1) & 255) | c;
         4'h8: m_res = (c << 7) | (a >> 1);
         4'h9: m_res = (a + 1) & 255;
         4'ha: m_res = (a - 1) & 255;
         4'hc: begin m_flg = (m_flg & 8'h0f) | 8'h10; m_st = m_st | 2; end
         4'hd: begin m_flg = m_flg & 8'h0f; m_st = m_st | 4; end
         default: ;
      endcase
      if (op == 4'h7 || op == 4'h8) m_flg = (m_flg & 8'h3e) | ((op == 4'h7) ? a >> 7 : a & 1);
      if (op >= 4'h4 && op <= 4'ha && op != 4'h7 && op != 4'h8)
         m_flg = (m_flg & 8'h3b) | ((m_res == 0) << 2);
   endtask

   task automatic ins(input [3:0] op, input [7:0] a, input [7:0] b);
      @(posedge aclk);
      instr_valid <= 1'b1; instr_op <= op; opnd_a <= a; opnd_b <= b;
      @(posedge aclk);
      instr_valid <= 1'b0;
      mop(op, a, b);
      @(posedge aclk);
      `CHK("result_valid", 1'b1, result_valid)
      if (op < `CPSF_OP_MOV) `CHK("result_data", m_res, result_data)
      `CHK("flags_out", m_flg, flags_out)
   endtask

   task automatic tmo;
      @(posedge aclk);
      wd_timeout <= 1'b1;
      @(posedge aclk);
      wd_timeout <= 1'b0;
      m_flg = m_flg | 8'h20; m_st = m_st | 1;
      @(posedge aclk);
      `CHK("flags_out", m_flg, flags_out)
   endtask

   task automatic irqchk;
      repeat (2) @(posedge aclk);
      `CHK("irq", (m_st & m_msk) != 0, irq)
   endtask

   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         n_mismatch++;
         finish_test();
      end
   end

   initial
   begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      `CHK("flags_out", 0, flags_out)
      for (i = 0; i <= 16; i += 4) rdchk(i[4:0], 0, `CPSF_RESP_OKAY);
      $display("test reset done");
      // system flags survive writes
      wr(`CPSF_OFS_FLAGS, 32'hff, `CPSF_RESP_OKAY);
      rdchk(`CPSF_OFS_FLAGS, 8'h0f, `CPSF_RESP_OKAY);
      `CHK("flags_out", 8'h0f, flags_out)
      $display("test write done");
      for (i = 0; i < 8; i++) ins(dir[i][19:16], dir[i][15:8], dir[i][7:0]);
      for (i = 0; i < 60; i++)
      begin
         rnd = lfsr(rnd);
         opnd_b <= rnd[7:0];
         rnd = lfsr(rnd);
         ins(4'(rnd % 12), rnd[15:8], opnd_b ^ rnd[7:0]);
      end
      ins(`CPSF_OP_ADD, 8'h3c, 8'h4d);
      rdchk(`CPSF_OFS_RESULT, (m_flg << 8) | m_res, `CPSF_RESP_OKAY);
      $display("test ops done");
      wr(`CPSF_OFS_RESULT, 32'h0, `CPSF_RESP_SLVERR);
      wr(5'h14, 32'h1, `CPSF_RESP_SLVERR);
      rdchk(5'h14, 0, `CPSF_RESP_SLVERR);
      wr(`CPSF_OFS_EVT_STAT, 32'hf, `CPSF_RESP_OKAY);
      $display("test errors done");
      // power-down and watchdog flags with events
      wr(`CPSF_OFS_EVT_MASK, 32'h7, `CPSF_RESP_OKAY);
      irqchk();
      tmo();
      irqchk();
      ins(`CPSF_OP_HALT, 8'h00, 8'h00);
      wr(`CPSF_OFS_FLAGS, 32'h0, `CPSF_RESP_OKAY);
      `CHK("flags_out", m_flg, flags_out)
      rdchk(`CPSF_OFS_EVT_STAT, m_st, `CPSF_RESP_OKAY);
      wr(`CPSF_OFS_EVT_STAT, 32'hf, `CPSF_RESP_OKAY);
      irqchk();
      tmo();
      ins(`CPSF_OP_KICK, 8'h00, 8'h00);
      wr(`CPSF_OFS_EVT_MASK, 32'h0, `CPSF_RESP_OKAY);
      irqchk();
      wr(`CPSF_OFS_EVT_MASK, 32'h4, `CPSF_RESP_OKAY);
      irqchk();
      rdchk(`CPSF_OFS_EVT_MASK, 4, `CPSF_RESP_OKAY);
      $display("test system flags done");
      finish_test();
   end
endmodule // tb_cpu_status_flag_register
`default_nettype wire
